/* File: hw/drf_regs.vh */
// Notes on behaviour
// - Ready output low while main or auxiliary result of an enabled converter waits unread.
// - A full serial read of the main or auxiliary result word clears that result's ready flag.
// - Unread result drops ready shortly before next update; host must not start then.
// - Ready goes low when a calibration cycle finishes.
// - Ready output is the NOR of the calibration hold and the ready flags of the enabled converters.
// - With one converter disabled, ready follows only the active converter.
// - After calibration, ready stays low until host writes the mode bits.
// - Serial output shifts from a register picked by the selection bits.
// - Reset pin low returns control, interface and filter logic to power-on state.
// - Filter sync pin low holds filter and calibration control in reset.
`ifndef DRF_REGS_VH
`define DRF_REGS_VH

`define DRF_ADDR_W          8
`define DRF_DATA_W          32
`define DRF_WORD_W          24

`define DRF_OFF_CTRL        8'h00
`define DRF_OFF_STATUS      8'h04
`define DRF_OFF_IRQ_STAT    8'h08
`define DRF_OFF_IRQ_MASK    8'h0C
`define DRF_OFF_MAIN_DATA   8'h10
`define DRF_OFF_AUX_DATA    8'h14

`define DRF_CTRL_W          7
`define DRF_CTRL_MAIN_EN    0
`define DRF_CTRL_AUX_EN     1
`define DRF_CTRL_MODE_LO    2
`define DRF_CTRL_MODE_HI    4
`define DRF_CTRL_SEL_LO     5
`define DRF_CTRL_SEL_HI     6
`define DRF_CTRL_RST        7'h03

`define DRF_MODE_IDLE       3'h0
`define DRF_MODE_CONT       3'h1
`define DRF_MODE_SINGLE     3'h2
`define DRF_MODE_CAL_BIT    2

`define DRF_SEL_STATUS      2'h0
`define DRF_SEL_CTRL        2'h1
`define DRF_SEL_MAIN        2'h2
`define DRF_SEL_AUX         2'h3

`define DRF_ST_W            7
`define DRF_ST_MAIN_FLAG    0
`define DRF_ST_AUX_FLAG     1
`define DRF_ST_CAL_HOLD     2
`define DRF_ST_CAL_BUSY     3
`define DRF_ST_READY_N      4
`define DRF_ST_SYNC_HOLD    5
`define DRF_ST_SHIFT_BUSY   6

`define DRF_IRQ_W           5
`define DRF_EV_MAIN         0
`define DRF_EV_AUX          1
`define DRF_EV_CAL          2
`define DRF_EV_READ         3
`define DRF_EV_DROP         4
`define DRF_IRQ_RST         5'h00

`endif

/* File: hw/drf_shift.v */
`timescale 1ns/100ps
module drf_shift #(
   parameter W = 24
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         clr,
   input  wire         load,
   input  wire [W-1:0] load_word,
   input  wire         rise,
   input  wire         fall,
   output reg          dout,
   output reg          busy,
   output reg          done
);
   localparam CW = $clog2(W + 1);
   localparam [CW-1:0] LAST = W - 1;

   reg [W-1:0]  sh_r;
   reg [CW-1:0] cnt_r;
   reg          rose_r;

   // MSB first; next bit leaves on the falling edge after each sampled rise
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sh_r   <= {W{1'b0}};
         cnt_r  <= {CW{1'b0}};
         rose_r <= 1'b0;
         dout   <= 1'b0;
         busy   <= 1'b0;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (clr) begin
            sh_r   <= {W{1'b0}};
            cnt_r  <= {CW{1'b0}};
            rose_r <= 1'b0;
            dout   <= 1'b0;
            busy   <= 1'b0;
         end else if (load) begin
            dout   <= load_word[W-1];
            sh_r   <= {load_word[W-2:0], 1'b0};
            cnt_r  <= {CW{1'b0}};
            rose_r <= 1'b0;
            busy   <= 1'b1;
         end else if (busy) begin
            if (rise) begin
               rose_r <= 1'b1;
               if (cnt_r == LAST) begin
                  done <= 1'b1;
                  busy <= 1'b0;
               end else begin
                  cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
               end
            end else if (fall && rose_r) begin
               dout   <= sh_r[W-1];
               sh_r   <= {sh_r[W-2:0], 1'b0};
               rose_r <= 1'b0;
            end
         end
      end
   end
endmodule // drf_shift

/* File: hw/drf_top.v */
`timescale 1ns/100ps
`include "drf_regs.vh"
module drf_top #(
   parameter W = `DRF_WORD_W
) (
   input  wire                    sys_clk,
   input  wire                    rst,
   input  wire [`DRF_ADDR_W-1:0]  reg_addr,
   input  wire [`DRF_DATA_W-1:0]  reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [`DRF_DATA_W-1:0]  reg_rdata,
   input  wire                    reset_pin_n,
   input  wire                    sync_pin_n,
   input  wire                    ser_clk_pin,
   input  wire                    ser_cs_pin_n,
   input  wire                    main_result_stb,
   input  wire [W-1:0]            main_result,
   input  wire                    aux_result_stb,
   input  wire [W-1:0]            aux_result,
   input  wire                    main_update_soon,
   input  wire                    aux_update_soon,
   input  wire                    cal_done_stb,
   output reg                     ready_n,
   output wire                    ser_dout,
   output reg                     irq,
   output reg                     filter_hold,
   output reg                     conv_start,
   output reg                     cal_start
);
   localparam RD_IDLE  = 1'b0;
   localparam RD_SHIFT = 1'b1;

   // Pin synchronisers: index 0 reset, 1 sync, 2 serial clock, 3 chip select
   reg [3:0] pin_s1_r;
   reg [3:0] pin_s2_r;
   reg [3:0] pin_s3_r;

   reg [`DRF_CTRL_W-1:0] ctrl_r;
   reg [`DRF_IRQ_W-1:0]  irq_stat_r;
   reg [`DRF_IRQ_W-1:0]  irq_mask_r;
   reg [W-1:0]           main_data_r;
   reg [W-1:0]           aux_data_r;
   reg                   main_flag_r;
   reg                   aux_flag_r;
   reg                   cal_hold_r;
   reg                   cal_busy_r;
   reg                   rd_state_r;
   reg [1:0]             src_r;

   reg                   rd_state_nxt;
   reg                   main_flag_nxt;
   reg                   aux_flag_nxt;
   reg [`DRF_IRQ_W-1:0]  ev_nxt;
   reg [W-1:0]           load_word;
   reg [`DRF_DATA_W-1:0] rd_mux;

   wire                  ctl_rst;
   wire                  sync_hold;
   wire                  sclk_rise;
   wire                  sclk_fall;
   wire                  cs_fall;
   wire                  cs_rise;
   wire                  wr_ctrl;
   wire                  wr_stat;
   wire                  wr_mask;
   wire [2:0]            wr_mode;
   wire                  main_en;
   wire                  aux_en;
   wire [1:0]            sel;
   wire                  sh_busy;
   wire                  sh_done;
   wire                  cs_load;
   wire                  cal_fin;
   wire                  main_read;
   wire                  aux_read;
   wire [`DRF_ST_W-1:0]  status;

   // Sticky flag update where a set beats a clear in the same cycle
   function flag_upd;
      input cur;
      input set;
      input clr;
      begin
         flag_upd = set | (cur & ~clr);
      end
   endfunction

   // Selection code names a result register
   function sel_is;
      input [1:0] s;
      input [1:0] want;
      begin
         sel_is = (s == want);
      end
   endfunction

   // Edges of a synchronised pin, seen between the last two stages
   function pin_rose;
      input cur;
      input prev;
      begin
         pin_rose = cur & ~prev;
      end
   endfunction

   function pin_fell;
      input cur;
      input prev;
      begin
         pin_fell = ~cur & prev;
      end
   endfunction

   // Write strobe aimed at one register offset
   function wr_hit;
      input                   wr;
      input [`DRF_ADDR_W-1:0] addr;
      input [`DRF_ADDR_W-1:0] off;
      begin
         wr_hit = wr && (addr == off);
      end
   endfunction

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_s1_r <= 4'hB;
         pin_s2_r <= 4'hB;
         pin_s3_r <= 4'hB;
      end else begin
         pin_s1_r <= {ser_cs_pin_n, ser_clk_pin, sync_pin_n, reset_pin_n};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   assign ctl_rst   = ~pin_s2_r[0];
   assign sync_hold = ~pin_s2_r[1];
   assign sclk_rise = pin_rose(pin_s2_r[2], pin_s3_r[2]);
   assign sclk_fall = pin_fell(pin_s2_r[2], pin_s3_r[2]);
   assign cs_fall   = pin_fell(pin_s2_r[3], pin_s3_r[3]);
   assign cs_rise   = pin_rose(pin_s2_r[3], pin_s3_r[3]);

   // Register write decode
   assign wr_ctrl = wr_hit(reg_wr, reg_addr, `DRF_OFF_CTRL);
   assign wr_stat = wr_hit(reg_wr, reg_addr, `DRF_OFF_IRQ_STAT);
   assign wr_mask = wr_hit(reg_wr, reg_addr, `DRF_OFF_IRQ_MASK);
   assign wr_mode = reg_wdata[`DRF_CTRL_MODE_HI:`DRF_CTRL_MODE_LO];

   // Control fields
   assign main_en = ctrl_r[`DRF_CTRL_MAIN_EN];
   assign aux_en  = ctrl_r[`DRF_CTRL_AUX_EN];
   assign sel     = ctrl_r[`DRF_CTRL_SEL_HI:`DRF_CTRL_SEL_LO];

   assign cs_load   = cs_fall && (rd_state_r == RD_IDLE);
   assign cal_fin   = cal_done_stb && cal_busy_r && !sync_hold;
   assign main_read = sh_done && sel_is(src_r, `DRF_SEL_MAIN);
   assign aux_read  = sh_done && sel_is(src_r, `DRF_SEL_AUX);

   assign status = {sh_busy, sync_hold, ready_n, cal_busy_r, cal_hold_r,
                    aux_flag_r, main_flag_r};

   // Word loaded into the output shifter follows the selection bits
   always @* begin
      load_word = {W{1'b0}};
      case (sel)
         `DRF_SEL_STATUS: load_word[`DRF_ST_W-1:0] = status;
         `DRF_SEL_CTRL:   load_word[`DRF_CTRL_W-1:0] = ctrl_r;
         `DRF_SEL_MAIN:   load_word = main_data_r;
         `DRF_SEL_AUX:    load_word = aux_data_r;
         default:         load_word = {W{1'b0}};
      endcase
   end

   drf_shift #(
      .W (W)
   ) u_shift (
      .clk       (sys_clk),
      .rst       (rst),
      .clr       (ctl_rst | cs_rise),
      .load      (cs_load),
      .load_word (load_word),
      .rise      (sclk_rise),
      .fall      (sclk_fall),
      .dout      (ser_dout),
      .busy      (sh_busy),
      .done      (sh_done)
   );

   // Readout sequence; a host waits for ready low before starting a read
   always @* begin
      rd_state_nxt = rd_state_r;
      case (rd_state_r)
         RD_IDLE: begin
            if (cs_load)
               rd_state_nxt = RD_SHIFT;
         end
         RD_SHIFT: begin
            if (cs_rise || sh_done)
               rd_state_nxt = RD_IDLE;
         end
         default: rd_state_nxt = RD_IDLE;
      endcase
   end

   // Ready flags: set on a latched result, cleared on a full read or before an update
   always @* begin
      main_flag_nxt = flag_upd(main_flag_r, main_result_stb,
                               main_read | main_update_soon);
      aux_flag_nxt  = flag_upd(aux_flag_r, aux_result_stb,
                               aux_read | aux_update_soon);
   end

   always @* begin
      ev_nxt = {`DRF_IRQ_W{1'b0}};
      ev_nxt[`DRF_EV_MAIN] = main_result_stb;
      ev_nxt[`DRF_EV_AUX]  = aux_result_stb;
      ev_nxt[`DRF_EV_CAL]  = cal_fin;
      ev_nxt[`DRF_EV_READ] = sh_done;
      ev_nxt[`DRF_EV_DROP] = (main_update_soon & main_flag_r & ~main_result_stb) |
                             (aux_update_soon & aux_flag_r & ~aux_result_stb);
   end

   // Readout sequencer and the source captured when a read starts
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_state_r <= RD_IDLE;
         src_r      <= `DRF_SEL_STATUS;
      end else if (ctl_rst) begin
         rd_state_r <= RD_IDLE;
         src_r      <= `DRF_SEL_STATUS;
      end else begin
         rd_state_r <= rd_state_nxt;
         if (cs_load)
            src_r <= sel;
      end
   end

   // Result latches and their ready flags
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         main_data_r <= {W{1'b0}};
         aux_data_r  <= {W{1'b0}};
         main_flag_r <= 1'b0;
         aux_flag_r  <= 1'b0;
      end else if (ctl_rst) begin
         main_data_r <= {W{1'b0}};
         aux_data_r  <= {W{1'b0}};
         main_flag_r <= 1'b0;
         aux_flag_r  <= 1'b0;
      end else begin
         if (main_result_stb)
            main_data_r <= main_result;
         if (aux_result_stb)
            aux_data_r <= aux_result;
         main_flag_r <= main_flag_nxt;
         aux_flag_r  <= aux_flag_nxt;
      end
   end

   // Mode writes start work and release the post-calibration hold
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_r     <= `DRF_CTRL_RST;
         cal_hold_r <= 1'b0;
         cal_busy_r <= 1'b0;
         conv_start <= 1'b0;
         cal_start  <= 1'b0;
      end else if (ctl_rst) begin
         ctrl_r     <= `DRF_CTRL_RST;
         cal_hold_r <= 1'b0;
         cal_busy_r <= 1'b0;
         conv_start <= 1'b0;
         cal_start  <= 1'b0;
      end else begin
         conv_start <= wr_ctrl && !wr_mode[`DRF_MODE_CAL_BIT] &&
                       (wr_mode != `DRF_MODE_IDLE);
         cal_start  <= wr_ctrl && wr_mode[`DRF_MODE_CAL_BIT] && !sync_hold;
         if (wr_ctrl)
            ctrl_r <= reg_wdata[`DRF_CTRL_W-1:0];
         else if (cal_fin)
            ctrl_r[`DRF_CTRL_MODE_HI:`DRF_CTRL_MODE_LO] <= `DRF_MODE_IDLE;
         if (cal_fin)
            cal_hold_r <= 1'b1;
         else if (wr_ctrl)
            cal_hold_r <= 1'b0;
         if (sync_hold)
            cal_busy_r <= 1'b0;
         else if (wr_ctrl)
            cal_busy_r <= wr_mode[`DRF_MODE_CAL_BIT];
         else if (cal_fin)
            cal_busy_r <= 1'b0;
      end
   end

   // Interrupt status and mask
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_stat_r <= `DRF_IRQ_RST;
         irq_mask_r <= `DRF_IRQ_RST;
      end else if (ctl_rst) begin
         irq_stat_r <= `DRF_IRQ_RST;
         irq_mask_r <= `DRF_IRQ_RST;
      end else begin
         irq_stat_r <= ev_nxt |
                       (irq_stat_r & ~({`DRF_IRQ_W{wr_stat}} &
                                       reg_wdata[`DRF_IRQ_W-1:0]));
         if (wr_mask)
            irq_mask_r <= reg_wdata[`DRF_IRQ_W-1:0];
      end
   end

   // Read data mux; unmapped offsets read zero
   always @* begin
      rd_mux = {`DRF_DATA_W{1'b0}};
      case (reg_addr)
         `DRF_OFF_CTRL:      rd_mux[`DRF_CTRL_W-1:0] = ctrl_r;
         `DRF_OFF_STATUS:    rd_mux[`DRF_ST_W-1:0] = status;
         `DRF_OFF_IRQ_STAT:  rd_mux[`DRF_IRQ_W-1:0] = irq_stat_r;
         `DRF_OFF_IRQ_MASK:  rd_mux[`DRF_IRQ_W-1:0] = irq_mask_r;
         `DRF_OFF_MAIN_DATA: rd_mux[W-1:0] = main_data_r;
         `DRF_OFF_AUX_DATA:  rd_mux[W-1:0] = aux_data_r;
         default:            rd_mux = {`DRF_DATA_W{1'b0}};
      endcase
   end

   // Registered outputs
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata   <= {`DRF_DATA_W{1'b0}};
         ready_n     <= 1'b1;
         irq         <= 1'b0;
         filter_hold <= 1'b1;
      end else begin
         reg_rdata   <= reg_rd ? rd_mux : {`DRF_DATA_W{1'b0}};
         irq         <= |(irq_stat_r & irq_mask_r);
         filter_hold <= ctl_rst | sync_hold;
         if (ctl_rst)
            ready_n <= 1'b1;
         else
            ready_n <= ~(cal_hold_r | (main_en & main_flag_r) |
                         (aux_en & aux_flag_r));
      end
   end
endmodule // drf_top

/* File: sim/drf_host_model.sv */
`timescale 1ns/100ps
module drf_host_model (
   input  wire sys_clk,
   input  wire ready_n,
   input  wire ser_dout,
   output reg  ser_clk_pin,
   output reg  ser_cs_pin_n
);
   // Serial clock idles low and stands still outside frames
   initial begin
      ser_clk_pin = 1'h0;
      ser_cs_pin_n = 1'h1;
   end
   // Reads one word MSB first; gap sets the pace, at least 4 cycles per edge
   task automatic read_word(input int gap, output logic [23:0] w);
      int n;
      n = 0;
      while (ready_n && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      @(posedge sys_clk);
      ser_cs_pin_n <= 1'h0;
      for (int i = 0; i < 24; i++) begin
         repeat (gap) @(posedge sys_clk);
         w = {w[22:0], ser_dout};
         ser_clk_pin <= 1'h1;
         repeat (gap) @(posedge sys_clk);
         ser_clk_pin <= 1'h0;
      end
      repeat (gap) @(posedge sys_clk);
      ser_cs_pin_n <= 1'h1;
   endtask
endmodule // drf_host_model

/* File: sim/drf_properties.sv */
`timescale 1ns/100ps
`include "drf_regs.vh"
module drf_properties (
   input wire                    sys_clk,
   input wire                    rst,
   input wire [`DRF_ADDR_W-1:0]  reg_addr,
   input wire [`DRF_DATA_W-1:0]  reg_wdata,
   input wire                    reg_wr,
   input wire                    reg_rd,
   input wire [`DRF_DATA_W-1:0]  reg_rdata,
   input wire                    reset_pin_n,
   input wire                    sync_pin_n,
   input wire                    main_result_stb,
   input wire                    cal_done_stb,
   input wire                    ready_n,
   input wire                    irq,
   input wire                    filter_hold,
   input wire                    conv_start,
   input wire                    cal_start
);
   wire ctrl_wr = reg_wr && reg_addr == `DRF_OFF_CTRL;
   reg  main_en_r;
   reg  busy_r;
   reg  hold_r;
   reg  mask_r;
   wire cal_ok = busy_r && cal_done_stb && sync_pin_n && reset_pin_n;
   // Shadow state, kept conservative so that it never claims more than the design holds
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         main_en_r <= 1'h1;
         busy_r    <= 1'h0;
         hold_r    <= 1'h0;
         mask_r    <= 1'h0;
      end else begin
         if (!reset_pin_n)
            main_en_r <= 1'h1;
         else if (ctrl_wr)
            main_en_r <= reg_wdata[`DRF_CTRL_MAIN_EN];
         busy_r <= reset_pin_n && sync_pin_n && !ctrl_wr && !cal_done_stb && (busy_r || cal_start);
         hold_r <= reset_pin_n && !ctrl_wr && (hold_r || cal_ok);
         if (reg_wr && reg_addr == `DRF_OFF_IRQ_MASK)
            mask_r <= |reg_wdata[4:0];
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_main_ready: assert property (main_result_stb && main_en_r && reset_pin_n |-> ##[1:2] !ready_n)
      else $error("ready not low after main result");
   a_cal_ready: assert property (cal_ok |-> ##[1:2] !ready_n)
      else $error("ready not low after calibration");
   a_cal_hold: assert property (hold_r && !ctrl_wr |=> !ready_n)
      else $error("ready released before mode write");
   a_sync_hold: assert property (!sync_pin_n [*5] |-> filter_hold)
      else $error("filter not held by sync pin");
   a_pin_reset: assert property (!reset_pin_n [*6] |-> ready_n && filter_hold)
      else $error("reset pin did not clear state");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero outside read");
   a_conv_pulse: assert property (ctrl_wr && reset_pin_n && !reg_wdata[4] && reg_wdata[3:2] != 2'h0
      |-> ##[1:2] conv_start ##1 !conv_start)
      else $error("conversion start pulse wrong");
   a_irq_quiet: assert property (!mask_r && !(reg_wr && reg_addr == `DRF_OFF_IRQ_MASK) |=> !irq)
      else $error("interrupt raised while all masked");
   cover property (cal_ok);
   cover property (main_result_stb && main_en_r);
   cover property ($fell(filter_hold));
endmodule // drf_properties

bind drf_top drf_properties u_props (
   .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reset_pin_n(reset_pin_n), .sync_pin_n(sync_pin_n),
   .main_result_stb(main_result_stb), .cal_done_stb(cal_done_stb), .ready_n(ready_n),
   .irq(irq), .filter_hold(filter_hold), .conv_start(conv_start), .cal_start(cal_start)
);

/* File: sim/dual_adc_ready_flag_logic_test.sv */
`timescale 1ns/100ps
`include "drf_regs.vh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module dual_adc_ready_flag_logic_test;
   typedef struct {bit wr; logic [7:0] a; logic [31:0] d;} drf_row_t;
   logic        sys_clk, rst, reg_wr, reg_rd, reset_pin_n, sync_pin_n;
   logic [4:0]  ev;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, d;
   logic [23:0] main_result, aux_result, w;
   wire  [31:0] reg_rdata;
   wire         ser_clk_pin, ser_cs_pin_n, ser_dout, ready_n, irq, filter_hold, conv_start;
   wire         cal_start;
   int          fails = 0;
   int          checks_done = 0;
   drf_row_t    rows[9] = '{'{1'h0, 8'h00, 32'h3}, '{1'h0, 8'h0C, 32'h0}, '{1'h0, 8'h08, 32'h0},
      '{1'h0, 8'h04, 32'h10}, '{1'h1, 8'h0C, 32'h1F}, '{1'h0, 8'h0C, 32'h1F},
      '{1'h0, 8'h20, 32'h0}, '{1'h1, 8'h20, 32'hFFFF}, '{1'h0, 8'h20, 32'h0}};
   drf_top DUT (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reset_pin_n(reset_pin_n),
      .sync_pin_n(sync_pin_n), .ser_clk_pin(ser_clk_pin), .ser_cs_pin_n(ser_cs_pin_n),
      .main_result_stb(ev[0]), .main_result(main_result), .aux_result_stb(ev[1]),
      .aux_result(aux_result), .main_update_soon(ev[2]), .aux_update_soon(ev[3]),
      .cal_done_stb(ev[4]), .ready_n(ready_n), .ser_dout(ser_dout), .irq(irq),
      .filter_hold(filter_hold), .conv_start(conv_start), .cal_start(cal_start)
   );
   drf_host_model host (
      .sys_clk(sys_clk), .ready_n(ready_n), .ser_dout(ser_dout),
      .ser_clk_pin(ser_clk_pin), .ser_cs_pin_n(ser_cs_pin_n)
   );
   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input [7:0] a, input [31:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input [7:0] a, output [31:0] v);
      @(posedge sys_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      #1 v = reg_rdata;
   endtask
   task automatic pulse(input [4:0] m);
      @(posedge sys_clk);
      ev <= m;
      @(posedge sys_clk);
      ev <= 5'h0;
   endtask
   task results;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      results;
   end
   initial begin
      rst = 1'h1;
      {reg_wr, reg_rd, reg_addr, reg_wdata, ev} = '0;
      {reset_pin_n, sync_pin_n} = 2'h3;
      main_result = 24'hA5C3E1;
      aux_result = 24'h5A1E7C;
      tick(20);
      @(posedge sys_clk) rst <= 1'h0;
      foreach (rows[i]) begin
         if (rows[i].wr)
            wr(rows[i].a, rows[i].d);
         else begin
            rd(rows[i].a, d);
            `CHK("register", rows[i].d, d)
         end
      end
      // Main result, then full serial word
      wr(`DRF_OFF_CTRL, 32'h47);
      #1;
      `CHK("conv start", 1'h1, conv_start)
      pulse(5'h01);
      tick(2);
      `CHK("ready_n set", 1'h0, ready_n)
      `CHK("irq raised", 1'h1, irq)
      rd(`DRF_OFF_STATUS, d);
      `CHK("main flag", 1'h1, d[`DRF_ST_MAIN_FLAG])
      host.read_word(6, w);
      `CHK("serial word", main_result, w)
      tick(3);
      `CHK("ready_n after read", 1'h1, ready_n)
      wr(`DRF_OFF_IRQ_STAT, 32'h1F);
      tick(2);
      `CHK("irq cleared", 1'h0, irq)
      // Auxiliary converter disabled, then enabled, read, then dropped
      wr(`DRF_OFF_IRQ_MASK, 32'h0);
      wr(`DRF_OFF_CTRL, 32'h61);
      pulse(5'h02);
      tick(2);
      `CHK("ready_n aux off", 1'h1, ready_n)
      `CHK("irq masked", 1'h0, irq)
      rd(`DRF_OFF_STATUS, d);
      `CHK("aux flag", 1'h1, d[`DRF_ST_AUX_FLAG])
      wr(`DRF_OFF_IRQ_MASK, 32'h2);
      wr(`DRF_OFF_CTRL, 32'h63);
      tick(2);
      `CHK("ready_n aux on", 1'h0, ready_n)
      `CHK("irq unmasked", 1'h1, irq)
      host.read_word(6, w);
      `CHK("aux serial word", aux_result, w)
      tick(3);
      `CHK("ready_n aux read", 1'h1, ready_n)
      pulse(5'h02);
      pulse(5'h08);
      tick(2);
      `CHK("ready_n dropped", 1'h1, ready_n)
      wr(`DRF_OFF_IRQ_STAT, 32'h1F);
      // Calibration completion holds ready low until a mode write
      wr(`DRF_OFF_CTRL, 32'h13);
      #1;
      `CHK("cal start", 1'h1, cal_start)
      `CHK("no conv on cal", 1'h0, conv_start)
      pulse(5'h10);
      tick(2);
      `CHK("ready_n cal", 1'h0, ready_n)
      tick(20);
      rd(`DRF_OFF_STATUS, d);
      `CHK("cal hold", 1'h1, d[`DRF_ST_CAL_HOLD])
      `CHK("ready_n held", 1'h0, ready_n)
      wr(`DRF_OFF_CTRL, 32'h03);
      tick(2);
      `CHK("ready_n released", 1'h1, ready_n)
      // Sync pin hold
      @(posedge sys_clk) sync_pin_n <= 1'h0;
      tick(5);
      `CHK("filter hold", 1'h1, filter_hold)
      rd(`DRF_OFF_STATUS, d);
      `CHK("sync hold", 1'h1, d[`DRF_ST_SYNC_HOLD])
      @(posedge sys_clk) sync_pin_n <= 1'h1;
      tick(5);
      `CHK("filter free", 1'h0, filter_hold)
      // Reset pin with a result pending
      pulse(5'h01);
      @(posedge sys_clk) reset_pin_n <= 1'h0;
      tick(6);
      `CHK("ready_n pin reset", 1'h1, ready_n)
      `CHK("filter pin reset", 1'h1, filter_hold)
      @(posedge sys_clk) reset_pin_n <= 1'h1;
      tick(5);
      rd(`DRF_OFF_STATUS, d);
      `CHK("status pin reset", 32'h10, d)
      rd(`DRF_OFF_IRQ_MASK, d);
      `CHK("mask pin reset", 32'h0, d)
      results;
   end
endmodule // dual_adc_ready_flag_logic_test
